// File: hw/ldar_pkg.sv
// Constants and types for the low-power, debounce and analog-mux register slice
package ldar_pkg;

  // Frame layout
  localparam int FRAME_BITS = 32;
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 25;
  localparam int RW_BIT = 24;
  localparam int DATA_MSB = 23;
  localparam int FAULT_BIT = 23;
  localparam int CHANGE_BIT = 22;

  // Register addresses
  localparam logic [6:0] ADDR_SUPPLY_DEB = 7'h1A;
  localparam logic [6:0] ADDR_GROUND_DEB = 7'h1B;
  localparam logic [6:0] ADDR_ENTER_LP = 7'h1C;
  localparam logic [6:0] ADDR_ANALOG_MUX_OUTPUT = 7'h1D;

  // Field widths and positions
  localparam int SUPPLY_COUNT = 8;
  localparam int GROUND_COUNT = 14;
  localparam int INPUT_COUNT = 22;
  localparam int ANALOG_MUX_OUTPUT_SOURCES = 24;
  localparam int ANALOG_MUX_OUTPUT_CUR_BIT = 6;
  localparam int ANALOG_MUX_OUTPUT_SEL_MSB = 5;

  // Reset values
  localparam logic [7:0] SUPPLY_DEB_RESET = 8'h00;
  localparam logic [13:0] GROUND_DEB_RESET = 14'h0000;
  localparam logic [5:0] ANALOG_MUX_OUTPUT_SEL_RESET = 6'h00;
  localparam logic ANALOG_MUX_OUTPUT_CUR_RESET = 1'b0;
  localparam logic [7:0] RESP_HEAD = 8'h00;

  // Channel select codes
  localparam logic [5:0] ANALOG_MUX_OUTPUT_CODE_NONE = 6'h00;
  localparam logic [5:0] ANALOG_MUX_OUTPUT_CODE_LAST_INPUT = 6'h16;
  localparam logic [5:0] ANALOG_MUX_OUTPUT_CODE_TEMP = 6'h17;
  localparam logic [5:0] ANALOG_MUX_OUTPUT_CODE_BATT = 6'h18;

  // Timing
  localparam int CLOCK_NS = 100;
  localparam int DEBOUNCE_US = 1200;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam int POLL_BASE_US = 100;
  localparam int POLL_BASE_CYCLES = (POLL_BASE_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam int POLL_PERIOD_US = 20000;
  localparam int POLL_PERIOD_CYCLES = (POLL_PERIOD_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam int TIMER_BITS = 24;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_LP_WAIT = 4'h2,
    ST_LP_BASE = 4'h4,
    ST_LP_DEB = 4'h8
  } ldar_state_t;

endpackage : ldar_pkg

// File: hw/ldar_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module ldar_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : ldar_sync

// File: hw/ldar_spi.sv
// Serial frame shifter: 32-bit frames, data in on clock rise, out on fall
`timescale 1ns/1ps
module ldar_spi (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Synchronised pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_out,
  // Frame side
  input wire logic [31:0] tx_word,
  output logic [31:0] frame,
  output logic frame_valid,
  output logic cs_fall
);

  logic sclk_d;
  logic cs_n_d;
  logic [31:0] rx;
  logic [31:0] tx;
  logic [5:0] bits;

  wire sclk_rise = sclk & ~sclk_d;
  wire sclk_fall = ~sclk & sclk_d;
  wire cs_rise = cs_n & ~cs_n_d;
  wire full = (bits == 6'h20);

  assign cs_fall = ~cs_n & cs_n_d;
  assign miso_out = tx[31];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      rx <= 32'h0000_0000;
      tx <= 32'h0000_0000;
      bits <= 6'h00;
      frame <= 32'h0000_0000;
      frame_valid <= 1'b0;
    end else begin
      sclk_d <= sclk;
      cs_n_d <= cs_n;
      frame_valid <= 1'b0;
      if (cs_fall) begin
        tx <= tx_word;
        bits <= 6'h00;
      end else if (!cs_n && sclk_rise) begin
        rx <= {rx[30:0], mosi};
        // Saturate so an overlong frame stays invalid
        if (bits != 6'h21) begin
          bits <= bits + 6'h01;
        end
      end else if (!cs_n && sclk_fall) begin
        tx <= {tx[30:0], 1'b0};
      end
      // Only exactly 32 clocks make a frame
      if (cs_rise && full) begin
        frame <= rx;
        frame_valid <= 1'b1;
      end
    end
  end

endmodule : ldar_spi

// File: hw/ldar_top.sv
// Debounce, low-power command and analog-mux register slice with serial port
`timescale 1ns/1ps

// How it works
// - Frame: address bits 31..25, read/write bit 24, data bits 23..0.
// - Debounce bit clear: decide change by voltage difference at poll end.
// - Debounce bit set: keep polling current 1.2 ms more, judge final level.
// - Supply debounce register 0x1A, bits 7..0, read/write, resets zero.
// - Ground debounce register 0x1B, bits 13..0, read/write, resets zero.
// - Only the low-power command enters the low-power state.
// - Low-power command: address 0x1C, write bit set, all data zero.
// - After the command, enter low power and start configured polling.
// - Leaving low power keeps every configuration register unchanged.
// - First transaction after low power returns both flags set and live inputs.
// - Channel select routes one of 24 sources to the analog output.
// - The selected input reads as 0 in the next returned word.
// - Host may rewrite analog select any time in normal operation.
// - After reset the channel select chooses no input.
// - Analog register 0x1D: current select bit 6, channel bits 5..0.
// - Current select lets wetting current flow into the selected input.
// - Current select 0 leaves the input high impedance, 1 sources current.
// - Code 0 none, 1-14 ground, 15-22 supply, 23 temperature, 24 battery.
// - Returned words carry fault summary in bit 23, change flag in 22.
module ldar_top #(
  parameter int DEBOUNCE_TICKS = ldar_pkg::DEBOUNCE_CYCLES,
  parameter int POLL_PERIOD_TICKS = ldar_pkg::POLL_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_drive_n,
  // Front end state, same clock
  input wire logic [21:0] switch_status,
  input wire logic [21:0] switch_changed,
  input wire logic fault_summary,
  input wire logic change_flag,
  input wire logic poll_enable,
  // Low-power polling controls
  output logic low_power_state,
  output logic [21:0] poll_current_en,
  output logic [21:0] diff_decide_strobe,
  output logic [21:0] final_sample_strobe,
  // Analog multiplexer
  output logic [23:0] analog_mux_output_route_en,
  output logic [21:0] analog_mux_output_wet_en,
  output logic analog_mux_output_source_current_sel,
  output logic [5:0] analog_mux_output_channel_sel,
  // Debounce enables
  output logic [7:0] supply_input_wake_debounce,
  output logic [13:0] ground_input_wake_debounce
);

  // Code to one-hot source, codes outside 1..24 select nothing
  function automatic logic [23:0] analog_mux_output_onehot(input logic [5:0] code);
    logic [23:0] hot;
    hot = 24'h000000;
    for (int i = 0; i < ldar_pkg::ANALOG_MUX_OUTPUT_SOURCES; i++) begin
      if (code == 6'(i + 1)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction : analog_mux_output_onehot

  logic rst_meta;
  logic rst_sync_n;
  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic [31:0] frame;
  logic frame_valid;
  logic cs_fall;
  logic [31:0] response_word;
  logic [31:0] next_response;
  ldar_pkg::ldar_state_t state;
  ldar_pkg::ldar_state_t next_state;
  logic [ldar_pkg::TIMER_BITS-1:0] timer;
  logic lp_exit;
  logic wake_hold;
  logic [31:0] tx_load;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ldar_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h2)
  ) u_pin_sync (
    .clock(clock),
    .rstn(rst_sync_n),
    .async_in({sclk, cs_n, mosi}),
    .sync_out({sclk_s, cs_n_s, mosi_s})
  );

  ldar_spi u_spi (
    .clock(clock),
    .rstn(rst_sync_n),
    .sclk(sclk_s),
    .cs_n(cs_n_s),
    .mosi(mosi_s),
    .miso_out(miso_out),
    .tx_word(tx_load),
    .frame(frame),
    .frame_valid(frame_valid),
    .cs_fall(cs_fall)
  );

  // Output released while deselected
  assign miso_drive_n = cs_n_s;

  // Frame fields
  wire [6:0] frame_addr = frame[ldar_pkg::ADDR_MSB:ldar_pkg::ADDR_LSB];
  wire frame_write = frame[ldar_pkg::RW_BIT];
  wire [23:0] frame_data = frame[ldar_pkg::DATA_MSB:0];
  wire in_normal = (state == ldar_pkg::ST_NORMAL);
  wire take = frame_valid & in_normal;

  wire hit_supply = (frame_addr == ldar_pkg::ADDR_SUPPLY_DEB);
  wire hit_ground = (frame_addr == ldar_pkg::ADDR_GROUND_DEB);
  wire hit_lp = (frame_addr == ldar_pkg::ADDR_ENTER_LP);
  wire hit_analog_mux_output = (frame_addr == ldar_pkg::ADDR_ANALOG_MUX_OUTPUT);
  wire wr_supply = take & frame_write & hit_supply;
  wire wr_ground = take & frame_write & hit_ground;
  wire wr_analog_mux_output = take & frame_write & hit_analog_mux_output;
  // A malformed command with nonzero data is ignored
  wire lp_cmd = take & frame_write & hit_lp & (frame_data == 24'h000000);

  // Configuration registers; low power never touches them
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      supply_input_wake_debounce <= ldar_pkg::SUPPLY_DEB_RESET;
      ground_input_wake_debounce <= ldar_pkg::GROUND_DEB_RESET;
      analog_mux_output_source_current_sel <= ldar_pkg::ANALOG_MUX_OUTPUT_CUR_RESET;
      analog_mux_output_channel_sel <= ldar_pkg::ANALOG_MUX_OUTPUT_SEL_RESET;
    end else begin
      if (wr_supply) begin
        supply_input_wake_debounce <= frame_data[ldar_pkg::SUPPLY_COUNT-1:0];
      end
      if (wr_ground) begin
        ground_input_wake_debounce <= frame_data[ldar_pkg::GROUND_COUNT-1:0];
      end
      if (wr_analog_mux_output) begin
        analog_mux_output_source_current_sel <= frame_data[ldar_pkg::ANALOG_MUX_OUTPUT_CUR_BIT];
        analog_mux_output_channel_sel <= frame_data[ldar_pkg::ANALOG_MUX_OUTPUT_SEL_MSB:0];
      end
    end
  end

  // Analog routing
  assign analog_mux_output_route_en = analog_mux_output_onehot(analog_mux_output_channel_sel);
  // Only switch inputs take wetting current, not temperature or battery
  assign analog_mux_output_wet_en = analog_mux_output_source_current_sel ? analog_mux_output_route_en[21:0] : 22'h000000;

  // Selected input reads as open
  wire [21:0] status_masked = switch_status & ~analog_mux_output_route_en[21:0];

  // Debounce mask in status bit order: ground low, supply high
  wire [21:0] deb_mask = {supply_input_wake_debounce, ground_input_wake_debounce};

  // Register read data, unused bits zero
  wire [21:0] reg_data =
    hit_supply ? {14'h0000, supply_input_wake_debounce} :
    hit_ground ? {8'h00, ground_input_wake_debounce} :
    hit_analog_mux_output ? {15'h0000, analog_mux_output_source_current_sel, analog_mux_output_channel_sel} :
    22'h000000;

  wire reg_hit = hit_supply | hit_ground | hit_analog_mux_output;
  wire [21:0] resp_body = reg_hit ? reg_data : status_masked;

  // Poll sequencing
  wire poll_due = poll_enable && (timer == ldar_pkg::TIMER_BITS'(POLL_PERIOD_TICKS - 1));
  wire base_done = (timer == ldar_pkg::TIMER_BITS'(ldar_pkg::POLL_BASE_CYCLES - 1));
  wire deb_done = (timer == ldar_pkg::TIMER_BITS'(DEBOUNCE_TICKS - 1));
  wire diff_hit = |(switch_changed & ~deb_mask);
  wire final_hit = |(switch_changed & deb_mask);
  wire any_deb = |deb_mask;

  always_comb begin
    next_state = state;
    lp_exit = 1'b0;
    case (state)
      ldar_pkg::ST_NORMAL: begin
        if (lp_cmd) begin
          next_state = ldar_pkg::ST_LP_WAIT;
        end
      end
      ldar_pkg::ST_LP_WAIT: begin
        if (cs_fall) begin
          lp_exit = 1'b1;
        end else if (poll_due) begin
          next_state = ldar_pkg::ST_LP_BASE;
        end
      end
      ldar_pkg::ST_LP_BASE: begin
        if (cs_fall || (base_done && diff_hit)) begin
          lp_exit = 1'b1;
        end else if (base_done) begin
          next_state = any_deb ? ldar_pkg::ST_LP_DEB : ldar_pkg::ST_LP_WAIT;
        end
      end
      ldar_pkg::ST_LP_DEB: begin
        if (cs_fall || (deb_done && final_hit)) begin
          lp_exit = 1'b1;
        end else if (deb_done) begin
          next_state = ldar_pkg::ST_LP_WAIT;
        end
      end
      default: begin
        next_state = ldar_pkg::ST_NORMAL;
      end
    endcase
    if (lp_exit) begin
      next_state = ldar_pkg::ST_NORMAL;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ldar_pkg::ST_NORMAL;
      timer <= '0;
    end else begin
      state <= next_state;
      // Timer restarts on every state change
      if (next_state != state) begin
        timer <= '0;
      end else if (state != ldar_pkg::ST_NORMAL) begin
        timer <= timer + ldar_pkg::TIMER_BITS'(1);
      end
    end
  end

  assign low_power_state = ~in_normal;

  // Base phase sources current on all inputs, extension only on debounced ones
  assign poll_current_en = (state == ldar_pkg::ST_LP_BASE) ? 22'h3FFFFF :
    (state == ldar_pkg::ST_LP_DEB) ? deb_mask : 22'h000000;
  assign diff_decide_strobe = ((state == ldar_pkg::ST_LP_BASE) && base_done) ? ~deb_mask : 22'h000000;
  assign final_sample_strobe = ((state == ldar_pkg::ST_LP_DEB) && deb_done) ? deb_mask : 22'h000000;

  // Response for the next frame
  always_comb begin
    next_response = response_word;
    if (lp_exit) begin
      // Wake word: both flags forced, live inputs
      next_response = {ldar_pkg::RESP_HEAD, 1'b1, 1'b1, status_masked};
    end else if (take) begin
      next_response = {ldar_pkg::RESP_HEAD, fault_summary, change_flag, resp_body};
    end else if (in_normal && cs_n_s && !wake_hold) begin
      // Idle: keep flags fresh for the next read, and status too unless the last frame addressed a register, read or write
      if (!reg_hit) begin
        next_response = {ldar_pkg::RESP_HEAD, fault_summary, change_flag, status_masked};
      end else begin
        next_response[ldar_pkg::FAULT_BIT] = fault_summary;
        next_response[ldar_pkg::CHANGE_BIT] = change_flag;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      response_word <= 32'h0000_0000;
    end else begin
      response_word <= next_response;
    end
  end

  // A waking frame loads the wake word directly, the stale word never leaves
  assign tx_load = lp_exit ? next_response : response_word;

  // Poll exit freezes the wake word against idle refresh until a frame loads it
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_hold <= 1'b0;
    end else if (lp_exit && !cs_fall) begin
      wake_hold <= 1'b1;
    end else if (cs_fall) begin
      wake_hold <= 1'b0;
    end
  end

endmodule : ldar_top

// File: tb/ldar_chk.sv
// Port-level assertion checker for the register slice
`timescale 1ns/1ps
module ldar_chk #(
  parameter int DEBOUNCE_TICKS = ldar_pkg::DEBOUNCE_CYCLES,
  parameter int POLL_PERIOD_TICKS = ldar_pkg::POLL_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial pins
  input wire logic cs_n,
  input wire logic miso_drive_n,
  // Polling
  input wire logic low_power_state,
  input wire logic [21:0] poll_current_en,
  input wire logic [21:0] diff_decide_strobe,
  input wire logic [21:0] final_sample_strobe,
  // Registers and mux
  input wire logic [23:0] analog_mux_output_route_en,
  input wire logic [21:0] analog_mux_output_wet_en,
  input wire logic analog_mux_output_source_current_sel,
  input wire logic [5:0] analog_mux_output_channel_sel,
  input wire logic [7:0] supply_input_wake_debounce,
  input wire logic [13:0] ground_input_wake_debounce
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic [21:0] deb = {supply_input_wake_debounce, ground_input_wake_debounce};
  sequence s_cs_idle;
    cs_n [*4];
  endsequence
  sequence s_lp_entry;
    !low_power_state ##1 low_power_state;
  endsequence
  AST_ROUTE_NONE: assert property ((analog_mux_output_channel_sel == 6'h00 || analog_mux_output_channel_sel > 6'h18) |-> !analog_mux_output_route_en)
    else $error("route set with no source");
  AST_ROUTE_ONE: assert property (analog_mux_output_channel_sel inside {[6'h01:6'h18]} |->
    analog_mux_output_route_en == 24'h000001 << (analog_mux_output_channel_sel - 6'h01)) else $error("wrong source routed");
  AST_WET_SRC: assert property (analog_mux_output_wet_en == (analog_mux_output_source_current_sel ? analog_mux_output_route_en[21:0] : 22'h000000))
    else $error("wetting current mismatch");
  AST_DIFF_MASK: assert property (|diff_decide_strobe |-> low_power_state && !(diff_decide_strobe & deb))
    else $error("difference decision on debounced input");
  AST_FINAL_MASK: assert property (|final_sample_strobe |-> poll_current_en == deb && $past(poll_current_en) == deb)
    else $error("final sample outside extension");
  AST_LP_ENTRY: assert property (s_lp_entry |-> cs_n && $past(cs_n, 2))
    else $error("low power entered outside a frame end");
  AST_CFG_HOLD: assert property (low_power_state [*2] |-> $stable({deb, analog_mux_output_source_current_sel, analog_mux_output_channel_sel}))
    else $error("configuration changed in low power");
  AST_NORMAL_QUIET: assert property (!low_power_state [*2] |-> !poll_current_en && !final_sample_strobe)
    else $error("polling active in normal state");
  AST_MISO_IDLE: assert property (s_cs_idle |-> miso_drive_n)
    else $error("data out driven while deselected");
endmodule : ldar_chk

bind ldar_top ldar_chk #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS), .POLL_PERIOD_TICKS(POLL_PERIOD_TICKS)) i_ldar_chk (
  .clock, .rstn, .cs_n, .miso_drive_n, .low_power_state, .poll_current_en, .diff_decide_strobe,
  .final_sample_strobe, .analog_mux_output_route_en, .analog_mux_output_wet_en, .analog_mux_output_source_current_sel, .analog_mux_output_channel_sel,
  .supply_input_wake_debounce, .ground_input_wake_debounce);

// File: tb/ldar_host.sv
// Host serial master model, mode 0, MSB first
`timescale 1ns/1ps
module ldar_host (
  // Clock
  input wire logic clock,
  // Serial pins
  input wire logic miso_out,
  input wire logic miso_drive_n,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Half link period of 4 clocks gives 400 ns
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      repeat (4) @(negedge clock);
      sclk = 1'b1;
      // Undriven line reads as the inverse of the pin
      r[i] = miso_drive_n ? ~miso_out : miso_out;
      repeat (4) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    // Released line must not hold the last bit
    mosi = ~mosi;
    repeat (12) @(negedge clock);
  endtask : xfer
endmodule : ldar_host

// File: tb/ldar_top_tb.sv
// Self-checking bench for the register slice
`timescale 1ns/1ps
module ldar_top_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic sclk, cs_n, mosi, miso_out, miso_drive_n, low_power_state, analog_mux_output_source_current_sel;
  logic [21:0] switch_status = '0, switch_changed = '0, poll_current_en, diff_decide_strobe;
  logic [21:0] final_sample_strobe, analog_mux_output_wet_en;
  logic fault_summary = 1'b0, change_flag = 1'b0, poll_enable = 1'b0;
  logic [23:0] analog_mux_output_route_en;
  logic [5:0] analog_mux_output_channel_sel;
  logic [7:0] supply_input_wake_debounce;
  logic [13:0] ground_input_wake_debounce;
  logic [7:0] m_sup = '0;
  logic [13:0] m_gnd = '0;
  logic [6:0] m_analog_mux_output = '0;
  logic [6:0] addr [4] = '{7'h1A, 7'h1B, 7'h1D, 7'h7F};
  logic [31:0] seed = 32'h0001527A;
  logic [31:0] r1, r2, e;
  int pv = -1;
  int bad_count = 0;
  int cmp_count = 0;

  always #50 clock = ~clock;

  ldar_top #(.DEBOUNCE_TICKS(20), .POLL_PERIOD_TICKS(50)) i_ldar_top (
    .clock, .rstn, .sclk, .cs_n, .mosi, .miso_out, .miso_drive_n, .switch_status, .switch_changed,
    .fault_summary, .change_flag, .poll_enable, .low_power_state, .poll_current_en, .diff_decide_strobe,
    .final_sample_strobe, .analog_mux_output_route_en, .analog_mux_output_wet_en, .analog_mux_output_source_current_sel, .analog_mux_output_channel_sel,
    .supply_input_wake_debounce, .ground_input_wake_debounce);
  ldar_host i_ldar_host (.clock, .miso_out, .miso_drive_n, .sclk, .cs_n, .mosi);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [23:0] route_of(input logic [5:0] c);
    return (c != 6'h00 && c <= 6'h18) ? 24'h000001 << (c - 6'h01) : 24'h000000;
  endfunction : route_of

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stir;
    seed = lfsr(seed);
    switch_status = seed[21:0];
    fault_summary = seed[22];
    change_flag = seed[23];
    seed = lfsr(seed);
  endtask : stir

  // Bounded wait for a polling strobe, sampled off the clock edge
  task automatic wait_nz(input logic fin, input int lim);
    int n;
    n = 0;
    while (n < lim && (fin ? final_sample_strobe : diff_decide_strobe) === 22'h000000) begin
      @(negedge clock);
      n++;
    end
    if (n == lim) begin
      bad_count++;
      report_and_stop;
    end
  endtask : wait_nz

  // Response of a frame reflects the frame before it
  task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] d);
    logic [23:0] er;
    logic [31:0] r;
    er = route_of(m_analog_mux_output[5:0]);
    e = {8'h00, fault_summary, change_flag, (pv >= 0) ? pv[21:0] : switch_status & ~er[21:0]};
    i_ldar_host.xfer({a, rw, d}, r);
    chk(r, e);
    pv = a == 7'h1A ? int'(m_sup) : a == 7'h1B ? int'(m_gnd) : a == 7'h1D ? int'(m_analog_mux_output) : -1;
    if (rw && a == 7'h1A) m_sup = d[7:0];
    if (rw && a == 7'h1B) m_gnd = d[13:0];
    if (rw && a == 7'h1D) m_analog_mux_output = d[6:0];
    er = route_of(m_analog_mux_output[5:0]);
    chk({4'h0, supply_input_wake_debounce, ground_input_wake_debounce, analog_mux_output_channel_sel},
      {4'h0, m_sup, m_gnd, m_analog_mux_output[5:0]});
    chk({7'h00, analog_mux_output_source_current_sel, analog_mux_output_route_en}, {7'h00, m_analog_mux_output[6], er});
    chk({10'h000, analog_mux_output_wet_en}, {10'h000, m_analog_mux_output[6] ? er[21:0] : 22'h000000});
  endtask : frame

  initial begin
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (8) @(negedge clock);
    chk({3'h0, supply_input_wake_debounce, ground_input_wake_debounce, analog_mux_output_channel_sel, low_power_state},
      32'h0);
    chk({7'h00, analog_mux_output_source_current_sel, analog_mux_output_route_en}, 32'h0);
    $display("end of reset test");
    for (int i = 0; i < 48; i++) begin
      stir;
      if (i < 26) frame(7'h1D, 1'b1, {seed[23:6], i[5:0]});
      else frame(addr[seed[25:24]], seed[26], seed[23:0]);
    end
    $display("end of register test");
    poll_enable = 1'b1;
    frame(7'h1A, 1'b1, 24'h0000A5);
    frame(7'h1B, 1'b1, 24'h00003C);
    frame(7'h1D, 1'b1, 24'h000043);
    frame(7'h1C, 1'b1, 24'h000100);
    chk({31'h0, low_power_state}, 32'h0);
    frame(7'h1C, 1'b1, 24'h000000);
    chk({31'h0, low_power_state}, 32'h1);
    wait_nz(1'b0, 3000);
    chk({10'h000, diff_decide_strobe}, {10'h000, ~m_sup, ~m_gnd});
    wait_nz(1'b1, 200);
    chk({10'h000, final_sample_strobe}, {10'h000, m_sup, m_gnd});
    chk({10'h000, poll_current_en}, {10'h000, m_sup, m_gnd});
    $display("end of low power test");
    stir;
    fault_summary = 1'b0;
    change_flag = 1'b0;
    e = {8'h00, 2'b11, switch_status & ~22'h000004};
    i_ldar_host.xfer(32'h3E000000, r1);
    i_ldar_host.xfer(32'h3E000000, r2);
    chk(r1, e);
    chk(r2, {8'h00, 2'b00, switch_status & ~22'h000004});
    chk({31'h0, low_power_state}, 32'h0);
    pv = -1;
    for (int i = 0; i < 4; i++) frame(addr[i], 1'b0, 24'h000000);
    $display("end of wake test");
    frame(7'h1C, 1'b1, 24'h000000);
    switch_changed = 22'h000001;
    wait_nz(1'b0, 3000);
    chk({10'h000, diff_decide_strobe}, {10'h000, ~m_sup, ~m_gnd});
    e = {8'h00, 2'b11, switch_status & ~22'h000004};
    repeat (2) @(negedge clock);
    chk({31'h0, low_power_state}, 32'h0);
    switch_changed = 22'h000000;
    stir;
    fault_summary = 1'b0;
    change_flag = 1'b0;
    repeat (20) @(negedge clock);
    i_ldar_host.xfer(32'h3E000000, r1);
    chk(r1, e);
    $display("end of poll exit test");
    report_and_stop;
  end
endmodule : ldar_top_tb
